// ### verilog/ocpwm_top.sv
// two-channel output compare and simple pwm unit with apb registers
//
// The APB register port is this design's own decision.
`timescale 1ns/1ps
// Function
// - each channel picks one of two 16-bit timers by control bit 3
// - select bit zero picks the first timer
// - modes 001/010/011 force low, force high, toggle on primary match
// - timer wrap before primary match leaves pin unchanged
// - 100 single pulse, 101 continuous: start primary, stop secondary
// - after single pulse, no pulse until mode 100 written again
// - modes 110/111 pwm; primary read-only latch, secondary buffer
// - pwm period is period plus one timer ticks
// - at period rollover load duty, set pin if new duty nonzero, raise timer flag
// - duty zero keeps pwm output low
// - duty above period keeps pwm output high
// - mode 111 low fault input tri-states output
// - fault state holds until fault gone and mode rewritten
// - fault sets channel compare interrupt flag
// - read-only fault status bit, clears after removal and rewrite
// - sleep holds pin level and resumes on wake
// - idle runs only if channel and timer idle-stop zero, timer on
// - non-pwm compare event pulses channel flag for one clock
// - pwm period events never set channel compare flag
module ocpwm_top
(
   input  wire logic                  clk_sys_i,
   input  wire logic                  rst_b_i,
   input  wire logic                  psel_i,
   input  wire logic                  penable_i,
   input  wire logic                  pwrite_i,
   input  wire logic [11:0]           paddr_i,
   input  wire logic [31:0]           pwdata_i,
   output logic      [31:0]           prdata_o,
   output logic                       pready_o,
   output logic                       pslverr_o,
   input  wire ocpwm_pkg::ocpwm_timer_t timer_a_i,
   input  wire ocpwm_pkg::ocpwm_timer_t timer_b_i,
   input  wire logic                  sleep_i,
   input  wire logic                  idle_i,
   input  wire logic                  fault_input_pin_b_i,
   output logic      [1:0]            compare_output_pin_o,
   output logic      [1:0]            compare_output_oe_b_o,
   output logic      [1:0]            channel_irq_flag_pulse_o,
   output logic                       first_timer_irq_pulse_o,
   output logic                       second_timer_irq_pulse_o
);
   // ==========================================================
   // helpers
   function automatic logic [11:0] byte_addr(input logic [9:0] idx);
      byte_addr = {idx, 2'b00};
   endfunction : byte_addr

   function automatic logic is_pwm(input logic [2:0] m);
      is_pwm = (m == ocpwm_pkg::M_PWM) || (m == ocpwm_pkg::M_PWMF);
   endfunction : is_pwm

   // ==========================================================
   // fault pin synchroniser
   logic fault_meta;
   logic fault_sync_b;
   always_ff @(posedge clk_sys_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         fault_meta   <= 1'b1;
         fault_sync_b <= 1'b1;
      end
      else
      begin
         fault_meta   <= fault_input_pin_b_i;
         fault_sync_b <= fault_meta;
      end
   end

   // ==========================================================
   // apb decode
   logic [15:0] secondary [2];
   logic [15:0] primary   [2];
   logic [2:0]  mode      [2];
   logic [1:0]  tsel;
   logic [1:0]  idle_stop;
   logic [1:0]  fault;
   logic [1:0]  pin;
   logic [1:0]  armed;

   wire access_w = psel_i & penable_i;
   wire wr_w     = access_w & pwrite_i;
   wire sec0_w   = paddr_i == byte_addr(ocpwm_pkg::CH1_SECONDARY_IDX);
   wire pri0_w   = paddr_i == byte_addr(ocpwm_pkg::CH1_PRIMARY_IDX);
   wire con0_w   = paddr_i == byte_addr(ocpwm_pkg::CH1_CONTROL_IDX);
   wire sec1_w   = paddr_i == byte_addr(ocpwm_pkg::CH2_SECONDARY_IDX);
   wire pri1_w   = paddr_i == byte_addr(ocpwm_pkg::CH2_PRIMARY_IDX);
   wire con1_w   = paddr_i == byte_addr(ocpwm_pkg::CH2_CONTROL_IDX);
   wire hit_w    = sec0_w | pri0_w | con0_w | sec1_w | pri1_w | con1_w;
   wire [1:0] sec_hit_w = {sec1_w, sec0_w};
   wire [1:0] pri_hit_w = {pri1_w, pri0_w};
   wire [1:0] con_hit_w = {con1_w, con0_w};

   function automatic logic [15:0] ctl_word(input int c);
      logic [15:0] w;
      w = 16'h0000;
      w[ocpwm_pkg::MODE_LSB +: 3]       = mode[c];
      w[ocpwm_pkg::TSEL_BIT]            = tsel[c];
      w[ocpwm_pkg::FAULT_BIT]           = fault[c];
      w[ocpwm_pkg::IDLE_STOP_BIT]       = idle_stop[c];
      ctl_word = w;
   endfunction : ctl_word

   logic [15:0] rd_mux;
   always_comb
   begin
      rd_mux = 16'h0000;
      if (sec0_w) rd_mux = secondary[0];
      if (pri0_w) rd_mux = primary[0];
      if (con0_w) rd_mux = ctl_word(0);
      if (sec1_w) rd_mux = secondary[1];
      if (pri1_w) rd_mux = primary[1];
      if (con1_w) rd_mux = ctl_word(1);
   end

   // access phase with one wait state: answer one edge after penable
   always_ff @(posedge clk_sys_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         prdata_o  <= 32'h0000_0000;
         pready_o  <= 1'b0;
         pslverr_o <= 1'b0;
      end
      else
      begin
         pready_o  <= access_w & ~pready_o;
         pslverr_o <= access_w & ~pready_o & ~hit_w;
         prdata_o  <= {16'h0000, rd_mux};
      end
   end
   wire commit_w = wr_w & pready_o;

   // ==========================================================
   // channels
   logic [1:0] pwm_tick;
   genvar c;
   generate
      for (c = 0; c < 2; c++)
      begin : g_ch
         ocpwm_pkg::ocpwm_timer_t tb;
         assign tb = tsel[c] ? timer_b_i : timer_a_i;
         wire run_w = ~sleep_i & tb.run &
                      ~(idle_i & (idle_stop[c] | tb.idle_stop));
         wire ev_w    = run_w & tb.tick;
         wire wrap_w  = tb.count == tb.period;
         wire pmatch_w = ev_w & (tb.count == primary[c]);
         wire smatch_w = ev_w & (tb.count == secondary[c]);
         wire mode_wr_w = commit_w & con_hit_w[c];
         wire [2:0] new_mode_w = pwdata_i[ocpwm_pkg::MODE_LSB +: 3];
         wire pwm_w  = is_pwm(mode[c]);
         wire flt_w  = (mode[c] == ocpwm_pkg::M_PWMF) & ~fault_sync_b;
         logic [15:0] next_primary;
         logic        next_pin;
         logic        cmp_ev;
         always_comb
         begin
            next_primary = primary[c];
            next_pin     = pin[c];
            cmp_ev       = 1'b0;
            case (mode[c])
               ocpwm_pkg::M_OFF: next_pin = 1'b0;
               ocpwm_pkg::M_LOW, ocpwm_pkg::M_HIGH, ocpwm_pkg::M_TOGGLE:
               begin
                  // a wrap before the match simply changes nothing
                  if (pmatch_w)
                  begin
                     cmp_ev = 1'b1;
                     if (mode[c] == ocpwm_pkg::M_LOW) next_pin = 1'b0;
                     else if (mode[c] == ocpwm_pkg::M_HIGH) next_pin = 1'b1;
                     else next_pin = ~pin[c];
                  end
               end
               ocpwm_pkg::M_SINGLE, ocpwm_pkg::M_CONT:
               begin
                  // relies on software ordering of compares
                  if (pmatch_w & armed[c])
                  begin
                     next_pin = 1'b1;
                     cmp_ev   = 1'b1;
                  end
                  if (smatch_w & pin[c])
                  begin
                     next_pin = 1'b0;
                     cmp_ev   = 1'b1;
                  end
               end
               default:
               begin
                  if (ev_w & wrap_w)
                  begin
                     next_primary = secondary[c];
                     next_pin = (secondary[c] != 16'h0000);
                  end
                  else if (ev_w & (tb.count + 16'h0001 == primary[c])
                           & (primary[c] <= tb.period))
                     next_pin = 1'b0;
               end
            endcase
         end
         assign pwm_tick[c] = pwm_w & ev_w & wrap_w;

         always_ff @(posedge clk_sys_i or negedge rst_b_i)
         begin
            if (!rst_b_i)
            begin
               secondary[c] <= ocpwm_pkg::COMPARE_RST;
               primary[c]   <= ocpwm_pkg::COMPARE_RST;
               mode[c]      <= ocpwm_pkg::MODE_RST;
               tsel[c]      <= 1'b0;
               idle_stop[c] <= 1'b0;
               fault[c]     <= 1'b0;
               pin[c]       <= 1'b0;
               armed[c]     <= 1'b0;
               channel_irq_flag_pulse_o[c] <= 1'b0;
               compare_output_pin_o[c]     <= 1'b0;
               compare_output_oe_b_o[c]    <= 1'b1;
            end
            else
            begin
               if (commit_w & sec_hit_w[c])
                  secondary[c] <= pwdata_i[15:0];
               // primary is read-only while in pwm
               if (commit_w & pri_hit_w[c] & ~pwm_w)
                  primary[c] <= pwdata_i[15:0];
               else
                  primary[c] <= next_primary;
               if (mode_wr_w)
               begin
                  mode[c]      <= new_mode_w;
                  tsel[c]      <= pwdata_i[ocpwm_pkg::TSEL_BIT];
                  idle_stop[c] <= pwdata_i[ocpwm_pkg::IDLE_STOP_BIT];
               end
               // set wins over the rewrite clear
               if (flt_w)
                  fault[c] <= 1'b1;
               else if (mode_wr_w & fault_sync_b)
                  fault[c] <= 1'b0;
               if (mode_wr_w)
                  armed[c] <= 1'b1;
               else if ((mode[c] == ocpwm_pkg::M_SINGLE) & smatch_w
                        & pin[c])
                  armed[c] <= 1'b0;
               else if (mode[c] == ocpwm_pkg::M_CONT)
                  armed[c] <= 1'b1;
               pin[c] <= next_pin;
               channel_irq_flag_pulse_o[c] <=
                  (cmp_ev & ~pwm_w) | (flt_w & ~fault[c]);
               compare_output_pin_o[c]  <= pin[c];
               compare_output_oe_b_o[c] <= fault[c] | flt_w;
            end
         end
      end
   endgenerate

   // timer flag pulses, combined over channels on that timer
   wire a_tick_w = (pwm_tick[0] & ~tsel[0]) | (pwm_tick[1] & ~tsel[1]);
   wire b_tick_w = (pwm_tick[0] & tsel[0]) | (pwm_tick[1] & tsel[1]);
   always_ff @(posedge clk_sys_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         first_timer_irq_pulse_o  <= 1'b0;
         second_timer_irq_pulse_o <= 1'b0;
      end
      else
      begin
         first_timer_irq_pulse_o  <= a_tick_w;
         second_timer_irq_pulse_o <= b_tick_w;
      end
   end
endmodule : ocpwm_top

// ### verilog/ocpwm_pkg.sv
// package: register map, fields and carriers for the compare channels
package ocpwm_pkg;
   // ==========================================================
   // register indices (printed offsets are not all word aligned)
   localparam logic [9:0] CH1_SECONDARY_IDX = 10'h180;
   localparam logic [9:0] CH1_PRIMARY_IDX   = 10'h182;
   localparam logic [9:0] CH1_CONTROL_IDX   = 10'h184;
   localparam logic [9:0] CH2_SECONDARY_IDX = 10'h186;
   localparam logic [9:0] CH2_PRIMARY_IDX   = 10'h188;
   localparam logic [9:0] CH2_CONTROL_IDX   = 10'h18A;
   localparam int         ADDR_W            = 12;
   // ==========================================================
   // control field positions
   localparam int MODE_LSB       = 0;
   localparam int TSEL_BIT       = 3;
   localparam int FAULT_BIT      = 4;
   localparam int IDLE_STOP_BIT  = 13;
   // ==========================================================
   // reset values
   localparam logic [15:0] COMPARE_RST = 16'h0000;
   localparam logic [2:0]  MODE_RST    = 3'h0;
   // ==========================================================
   // modes
   localparam logic [2:0] M_OFF    = 3'h0;
   localparam logic [2:0] M_LOW    = 3'h1;
   localparam logic [2:0] M_HIGH   = 3'h2;
   localparam logic [2:0] M_TOGGLE = 3'h3;
   localparam logic [2:0] M_SINGLE = 3'h4;
   localparam logic [2:0] M_CONT   = 3'h5;
   localparam logic [2:0] M_PWM    = 3'h6;
   localparam logic [2:0] M_PWMF   = 3'h7;

   // one timer's view as the channel sees it
   typedef struct packed {
      logic [15:0] count;
      logic [15:0] period;
      logic        run;
      logic        idle_stop;
      logic        tick;
   } ocpwm_timer_t;
endpackage : ocpwm_pkg

// ### tb/ocpwm_assertions.sv
// checker: port-level assertions for the compare channel block
`timescale 1ns/1ps
module ocpwm_assertions
(
   input wire logic                    clk_sys_i,
   input wire logic                    rst_b_i,
   input wire logic                    psel_i,
   input wire logic                    penable_i,
   input wire logic                    pready_o,
   input wire logic                    pslverr_o,
   input wire ocpwm_pkg::ocpwm_timer_t timer_a_i,
   input wire ocpwm_pkg::ocpwm_timer_t timer_b_i,
   input wire logic                    sleep_i,
   input wire logic                    idle_i,
   input wire logic [1:0]              compare_output_pin_o,
   input wire logic [1:0]              channel_irq_flag_pulse_o,
   input wire logic                    first_timer_irq_pulse_o,
   input wire logic                    second_timer_irq_pulse_o
);
   // ==========================================================
   // properties
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rst_b_i);
   logic tick_any;
   assign tick_any = timer_a_i.tick | timer_b_i.tick;
   sequence s_access;
      psel_i && penable_i && !pready_o;
   endsequence
   sequence s_answer;
      pready_o ##1 !pready_o;
   endsequence
   chk_apb_wait: assert property (s_access |=> s_answer)
      else $error("ready not one cycle after access");
   chk_slverr_ready: assert property (pslverr_o |->
      pready_o && $past(psel_i && penable_i))
      else $error("error response outside an access");
   chk_sleep_hold: assert property (
      sleep_i[*3] |-> $stable(compare_output_pin_o))
      else $error("pin moved while asleep");
   chk_sleep_no_irq: assert property (
      sleep_i && $past(sleep_i) |-> channel_irq_flag_pulse_o == 2'h0)
      else $error("compare flag raised while asleep");
   chk_idle_freeze: assert property (
      (idle_i && !timer_a_i.run && !timer_b_i.run)[*3]
      |-> $stable(compare_output_pin_o))
      else $error("pin moved in idle with timers off");
   chk_pin_cause: assert property (!$stable(compare_output_pin_o) |->
      $past(tick_any, 2) || $past(pready_o) || $past(pready_o, 2)
      || $past(pready_o, 3))
      else $error("pin changed without timer tick or write");
   chk_tmr_a_irq: assert property (first_timer_irq_pulse_o |->
      $past(timer_a_i.tick && timer_a_i.count == timer_a_i.period))
      else $error("first timer flag without rollover");
   chk_tmr_b_irq: assert property (second_timer_irq_pulse_o |->
      $past(timer_b_i.tick && timer_b_i.count == timer_b_i.period))
      else $error("second timer flag without rollover");
endmodule : ocpwm_assertions
bind ocpwm_top ocpwm_assertions i_chk (.*);

// ### tb/ocpwm_load.sv
// partner: load on the compare pins, resolving the wire level
`timescale 1ns/1ps
module ocpwm_load
(
   input  wire logic [1:0] pin_i,
   input  wire logic [1:0] oe_b_i,
   output logic      [1:0] lvl_o
);
   // no pull on the line: released shows the inverse of the last drive
   logic [1:0] last = 2'h0;
   always @(pin_i, oe_b_i) last = (pin_i & ~oe_b_i) | (last & oe_b_i);
   assign lvl_o = (pin_i & ~oe_b_i) | (~last & oe_b_i);
endmodule : ocpwm_load

// ### tb/tb_top.sv
// testbench: registers, compare, pwm, fault and power-state scenarios
`timescale 1ns/1ps
module tb_top;
   // ==========================================================
   // signals
   logic        clk_sys_i = 1'b0;
   logic        rst_b_i   = 1'b0;
   logic        psel = 1'b0, pen = 1'b0, pwr = 1'b0, rdy, se, sev;
   logic        slp = 1'b0, idl = 1'b0, flt_b = 1'b1, ti1, ti2;
   logic [11:0] pa  = 12'h000;
   logic [31:0] pwd = 32'h0000_0000, prd;
   logic [1:0]  pin, oeb, chirq, lvl;
   logic [15:0] q, rv, d;
   ocpwm_pkg::ocpwm_timer_t tma = '{16'h0, 16'h9, 1'b1, 1'b0, 1'b1};
   ocpwm_pkg::ocpwm_timer_t tmb = '{16'h0, 16'h13, 1'b1, 1'b0, 1'b1};
   int err_total = 0, n_checks = 0, seed = 18965, hi_n, rs_n, ir_n, ti_n;
   logic [9:0] ix [6] = '{ocpwm_pkg::CH1_SECONDARY_IDX,
      ocpwm_pkg::CH1_PRIMARY_IDX, ocpwm_pkg::CH1_CONTROL_IDX,
      ocpwm_pkg::CH2_SECONDARY_IDX, ocpwm_pkg::CH2_PRIMARY_IDX,
      ocpwm_pkg::CH2_CONTROL_IDX};
   logic [15:0] duty [3] = '{16'h0003, 16'h0000, 16'h000C};
   always #20 clk_sys_i = ~clk_sys_i;
   function automatic logic [15:0] nx(ocpwm_pkg::ocpwm_timer_t t);
      return !t.run ? t.count
             : t.count == t.period ? 16'h0 : t.count + 16'h1;
   endfunction : nx
   always @(posedge clk_sys_i)
   begin
      tma.count <= nx(tma);
      tmb.count <= nx(tmb);
   end
   ocpwm_top i_dut
   (
      .clk_sys_i, .rst_b_i, .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
      .paddr_i(pa), .pwdata_i(pwd), .prdata_o(prd), .pready_o(rdy),
      .pslverr_o(se), .timer_a_i(tma), .timer_b_i(tmb), .sleep_i(slp),
      .idle_i(idl), .fault_input_pin_b_i(flt_b),
      .compare_output_pin_o(pin), .compare_output_oe_b_o(oeb),
      .channel_irq_flag_pulse_o(chirq), .first_timer_irq_pulse_o(ti1),
      .second_timer_irq_pulse_o(ti2)
   );
   ocpwm_load i_load (.pin_i(pin), .oe_b_i(oeb), .lvl_o(lvl));
   task automatic chk(input string nm, input logic [31:0] s, e);
      n_checks++;
      if (s !== e)
      begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", nm, e, s);
      end
   endtask : chk
   task automatic results;
      if (err_total == 0 && n_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : results
   // index 6 is an unmapped word
   task automatic apb(input logic w, input int i, input logic [15:0] v);
      int n;
      n = 0;
      @(posedge clk_sys_i);
      psel <= 1'b1;
      pen  <= 1'b0;
      pwr  <= w;
      pa   <= (i < 6) ? {ix[i], 2'b00} : 12'h604;
      pwd  <= {16'h0000, v};
      @(posedge clk_sys_i);
      pen <= 1'b1;
      do
      begin
         @(posedge clk_sys_i);
         n++;
         if (n > 20)
         begin
            err_total++;
            results();
         end
      end
      while (rdy !== 1'b1);
      q = prd[15:0];
      sev = se;
      psel <= 1'b0;
      pen  <= 1'b0;
   endtask : apb
   task automatic meas(input int ch, input int settle, input int cyc);
      logic p;
      repeat (settle) @(posedge clk_sys_i);
      {hi_n, rs_n, ir_n, ti_n} = 0;
      p = lvl[ch];
      repeat (cyc)
      begin
         @(posedge clk_sys_i);
         hi_n += int'(lvl[ch] === 1'b1);
         rs_n += int'(lvl[ch] === 1'b1 && p === 1'b0);
         ir_n += int'(chirq[ch] === 1'b1);
         ti_n += int'(ti1 === 1'b1);
         p = lvl[ch];
      end
   endtask : meas
   initial
   begin
      repeat (2) @(posedge clk_sys_i);
      rst_b_i <= 1'b1;
      for (int i = 0; i < 6; i++)
      begin
         apb(1'b0, i, 16'h0);
         chk("reset value", q, 16'h0000);
      end
      apb(1'b0, 6, 16'h0);
      chk("unmapped error", sev, 1'b1);
      rv = 16'($random(seed));
      apb(1'b1, 0, rv);
      apb(1'b0, 0, 16'h0);
      chk("secondary rw", q, rv);
      apb(1'b1, 2, 16'h0010);
      apb(1'b0, 2, 16'h0);
      chk("fault bit read only", q, 16'h0000);
      apb(1'b1, 1, 16'h0005);
      apb(1'b1, 2, 16'h0003);
      meas(0, 15, 40);
      chk("toggle rises", rs_n, 2);
      chk("toggle flags", ir_n, 4);
      apb(1'b1, 4, 16'h000F);
      apb(1'b1, 5, 16'h0002);
      meas(1, 15, 40);
      chk("wrap before match", rs_n + hi_n, 0);
      apb(1'b1, 5, 16'h000A);
      meas(1, 15, 40);
      chk("second timer high", lvl[1], 1'b1);
      chk("second timer flags", ir_n, 2);
      apb(1'b1, 5, 16'h0009);
      meas(1, 25, 20);
      chk("force low", hi_n, 0);
      for (int k = 0; k < 3; k++)
      begin
         d = duty[k];
         apb(1'b1, 0, d);
         apb(1'b1, 2, 16'h0006);
         meas(0, 15, 50);
         chk("pwm high", hi_n,
             d > tma.period ? 50 : 50 * d / (tma.period + 1));
         chk("pwm periods", ti_n, 5);
         chk("pwm no flag", ir_n, 0);
         apb(1'b1, 1, 16'h0007);
         apb(1'b0, 1, 16'h0);
         chk("duty latch", q, d);
      end
      apb(1'b1, 2, 16'h0007);
      flt_b <= 1'b0;
      meas(0, 0, 10);
      chk("fault tristate", oeb[0], 1'b1);
      chk("fault flag", ir_n, 1);
      apb(1'b0, 2, 16'h0);
      chk("fault status", q, 16'h0017);
      apb(1'b1, 2, 16'h0007);
      flt_b <= 1'b1;
      meas(0, 0, 5);
      chk("fault held", oeb[0], 1'b1);
      apb(1'b1, 2, 16'h0007);
      meas(0, 0, 5);
      chk("fault cleared", oeb[0], 1'b0);
      apb(1'b0, 2, 16'h0);
      chk("fault status clear", q, 16'h0007);
      apb(1'b1, 4, 16'h0002);
      apb(1'b1, 3, 16'h0006);
      apb(1'b1, 5, 16'h0000);
      meas(1, 5, 0);
      chk("mode off low", lvl[1], 1'b0);
      for (int k = 0; k < 2; k++)
      begin
         apb(1'b1, 5, 16'h0004);
         meas(1, 0, 60);
         chk("single pulse", rs_n, 1);
      end
      apb(1'b1, 5, 16'h0005);
      meas(1, 15, 60);
      chk("continuous pulses", rs_n, 6);
      slp <= 1'b1;
      meas(1, 3, 60);
      chk("sleep hold", rs_n, 0);
      slp <= 1'b0;
      meas(1, 15, 60);
      chk("wake resume", rs_n, 6);
      apb(1'b1, 5, 16'h2005);
      idl <= 1'b1;
      meas(1, 3, 60);
      chk("idle stop", rs_n, 0);
      {tma.run, tma.tick, tmb.run, tmb.tick} <= 4'h0;
      meas(1, 3, 10);
      {tma.run, tma.tick, tmb.run, tmb.tick} <= 4'hF;
      idl <= 1'b0;
      meas(1, 15, 60);
      chk("idle exit", rs_n, 6);
      results();
   end
endmodule : tb_top
